// [rtl/acs_pkg.sv]
// Behaviour
// - software start bit, with power reduction off, begins one conversion; cleared at end
// - channel change during a conversion applies only after it completes
// - auto trigger rising edge resets prescaler and starts a conversion
// - trigger high at completion or edges during conversion start nothing
// - done flag sets regardless of interrupt enables; software clears it
// - done flag as trigger gives free running; first started by start bit
// - start bit works with auto trigger; start bit reads one while busy
// - prescaler counts while enable set, held in reset while enable low
// - software start begins at the next rising converter clock edge
// - normal conversion 13 converter cycles, first after enable 25
// - sample at 1.5 cycles normally, 13.5 cycles on first conversion
// - at completion write result, set done flag, clear start bit in single mode
// - auto triggered: sample 2 cycles after trigger, three core cycles sync
// - free running restarts immediately and keeps start bit high
// - selection buffer copies until start, freezes, resumes in last cycle
// - free running: change after first completion affects later results only
// - input above reference yields full scale code
// - low byte read blocks result update until high byte read
// - result right adjusted by default, left adjusted with left adjust bit
// - selections not applied until converter enable bit set
package acs_pkg;
  // register byte addresses on the apb bus
  localparam logic [7:0] ACS_CTRL_A_OFS = 8'h00;
  localparam logic [7:0] ACS_CTRL_B_OFS = 8'h04;
  localparam logic [7:0] ACS_INSEL_OFS = 8'h08;
  localparam logic [7:0] ACS_RES_LO_OFS = 8'h0C;
  localparam logic [7:0] ACS_RES_HI_OFS = 8'h10;
  localparam logic [7:0] ACS_PWR_OFS = 8'h14;
  // control a bit positions
  localparam int ACS_EN_BIT = 7;
  localparam int ACS_START_BIT = 6;
  localparam int ACS_ATE_BIT = 5;
  localparam int ACS_DONE_BIT = 4;
  localparam int ACS_PS_LSB = 0;
  // input select bit positions
  localparam int ACS_REF_LSB = 6;
  localparam int ACS_LADJ_BIT = 5;
  localparam int ACS_CH_LSB = 0;
  // conversion timing in converter clock cycles, sample instants in half cycles; then trigger select and power defaults
  localparam logic [5:0] ACS_NORM_CYC = 6'h0D;
  localparam logic [5:0] ACS_FIRST_CYC = 6'h19;
  localparam logic [5:0] ACS_NORM_SH_HALF = 6'h03;
  localparam logic [5:0] ACS_FIRST_SH_HALF = 6'h1B;
  localparam logic [5:0] ACS_AUTO_SH_HALF = 6'h04;
  localparam logic [2:0] ACS_TS_FREE = 3'h0;
  localparam logic [31:0] ACS_PWR_RST = 32'h0000_0001;
  // frozen selection carried to the analog front end
  typedef struct packed {
    logic [1:0] ref_sel;
    logic [3:0] chan_sel;
  } acs_sel_t;
  typedef enum logic [1:0] {
    ACS_IDLE = 2'b01,
    ACS_CONV = 2'b10
  } acs_state_t;
endpackage

// [rtl/acs_adc_conversion_sequencer.sv]
// Decided for this implementation: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module acs_adc_conversion_sequencer
  import acs_pkg::*;
#(
  parameter int TRIG_W = 8 // number of auto trigger sources
)
(
  input wire logic CORE_CLK_I, // 20 MHz core clock
  input wire logic RST_N_I, // async reset, active low
  input wire logic PSEL_I, // apb select
  input wire logic PENABLE_I, // apb access phase
  input wire logic PWRITE_I, // apb direction
  input wire logic [7:0] PADDR_I, // apb byte address
  input wire logic [31:0] PWDATA_I, // apb write data
  output logic [31:0] PRDATA_O, // apb read data
  output logic PREADY_O, // apb ready, always one
  output logic PSLVERR_O, // apb error on unmapped address
  input wire logic [TRIG_W-1:1] TRIG_I, // on-chip trigger sources, same clock
  input wire logic [9:0] CONV_CODE_I, // code from successive approximation array
  output logic SAMPLE_O, // one-cycle pulse at sample and hold instant
  output logic [5:0] SEL_O, // frozen reference and channel selection
  output logic CONV_DONE_O, // one-cycle pulse at conversion end
  output logic CONV_BUSY_O // conversion in progress
);
  logic apb_wr;
  logic apb_rd;
  logic [31:0] ctrl_a_q, ctrl_a_d;
  logic [2:0] tsel_q, tsel_d;
  logic [7:0] insel_q, insel_d;
  logic pwr_red_q, pwr_red_d;
  logic [9:0] res_q, res_d;
  logic lock_q, lock_d;
  logic [6:0] pre_q, pre_d;
  logic [7:0] pre_div;
  logic adc_edge;
  logic adc_fall;
  acs_state_t st_q, st_d;
  logic [5:0] half_q, half_d;
  logic [5:0] len_q, len_d;
  logic [5:0] sh_q, sh_d;
  logic first_q, first_d;
  logic pend_q, pend_d;
  logic trig_q, trig_d;
  logic [2:0] sync_q, sync_d;
  acs_sel_t sel_q, sel_d;
  logic trig_now;
  logic start_req;
  logic auto_start;
  logic done;
  logic free_run;
  logic sample;

  // prescaler divide factor from the 3-bit select field
  function automatic logic [7:0] div_of(input logic [2:0] ps);
    div_of = (ps == 3'h0) ? 8'h02 : 8'(8'h01 << ps); // eight bits, so divide by 128 does not wrap to zero
  endfunction

  assign apb_wr = PSEL_I & PENABLE_I & PWRITE_I;
  assign apb_rd = PSEL_I & PENABLE_I & ~PWRITE_I;
  assign PREADY_O = 1'b1;
  assign free_run = ctrl_a_q[ACS_ATE_BIT] & (tsel_q == ACS_TS_FREE);
  assign trig_now = (tsel_q == ACS_TS_FREE) ? ctrl_a_q[ACS_DONE_BIT] : TRIG_I[tsel_q];
  assign pre_div = div_of(ctrl_a_q[ACS_PS_LSB +: 3]);
  // one rising converter edge per divided period, a falling half way
  assign adc_edge = ctrl_a_q[ACS_EN_BIT] && ({1'b0, pre_q} == pre_div - 8'h01);
  assign adc_fall = ctrl_a_q[ACS_EN_BIT] && ({1'b0, pre_q} == (pre_div >> 1) - 8'h01);
  // rising edges meet odd half counts, so the closing edge sees twice the length minus one
  assign done = (st_q == ACS_CONV) && adc_edge && (half_q == (len_q << 1) - 6'h01) && !sync_q[0];
  assign sample = (st_q == ACS_CONV) && (adc_edge || adc_fall) && (half_q == sh_q - 6'h01) && sync_q == 3'h0;
  // auto trigger start after three core cycles of synchronisation
  assign auto_start = sync_q[2] && (st_q == ACS_IDLE);
  assign start_req = pend_q && adc_edge && (st_q == ACS_IDLE);

  // apb decode; unmapped addresses answer with pslverr
  always_comb
  begin
    PRDATA_O = 32'h0000_0000;
    PSLVERR_O = 1'b0;
    if (PADDR_I == ACS_CTRL_A_OFS)
      PRDATA_O = {24'h00_0000, ctrl_a_q[7:0]};
    else if (PADDR_I == ACS_CTRL_B_OFS)
      PRDATA_O = {29'h0000_0000, tsel_q};
    else if (PADDR_I == ACS_INSEL_OFS)
      PRDATA_O = {24'h00_0000, insel_q[7:5], 1'b0, insel_q[3:0]};
    else if (PADDR_I == ACS_RES_LO_OFS)
      PRDATA_O = insel_q[ACS_LADJ_BIT] ? {24'h00_0000, res_q[1:0], 6'h00} : {24'h00_0000, res_q[7:0]};
    else if (PADDR_I == ACS_RES_HI_OFS)
      PRDATA_O = insel_q[ACS_LADJ_BIT] ? {24'h00_0000, res_q[9:2]} : {30'h0000_0000, res_q[9:8]};
    else if (PADDR_I == ACS_PWR_OFS)
      PRDATA_O = {31'h0000_0000, pwr_red_q};
    else
      PSLVERR_O = PSEL_I & PENABLE_I;
  end

  // software registers, start bit and done flag
  always_comb
  begin
    ctrl_a_d = ctrl_a_q;
    tsel_d = tsel_q;
    insel_d = insel_q;
    pwr_red_d = pwr_red_q;
    pend_d = pend_q;
    if (apb_wr && PADDR_I == ACS_CTRL_A_OFS)
    begin
      ctrl_a_d[7:0] = {PWDATA_I[7], ctrl_a_q[6], PWDATA_I[5], ctrl_a_q[4], PWDATA_I[3:0]};
      if (PWDATA_I[ACS_START_BIT] && !pwr_red_q && PWDATA_I[ACS_EN_BIT])
      begin
        ctrl_a_d[ACS_START_BIT] = 1'b1;
        pend_d = (st_q == ACS_IDLE);
      end
      if (PWDATA_I[ACS_DONE_BIT]) // write one clears done flag
        ctrl_a_d[ACS_DONE_BIT] = 1'b0;
    end
    if (apb_wr && PADDR_I == ACS_CTRL_B_OFS)
      tsel_d = PWDATA_I[2:0];
    if (apb_wr && PADDR_I == ACS_INSEL_OFS)
      insel_d = {PWDATA_I[7:5], 1'b0, PWDATA_I[3:0]};
    if (apb_wr && PADDR_I == ACS_PWR_OFS)
      pwr_red_d = PWDATA_I[0];
    if (start_req || auto_start)
      pend_d = 1'b0;
    if (auto_start)
      ctrl_a_d[ACS_START_BIT] = 1'b1;
    // set wins over a same-cycle software clear
    if (done)
      ctrl_a_d[ACS_DONE_BIT] = 1'b1;
    if (done && !free_run)
      ctrl_a_d[ACS_START_BIT] = 1'b0;
    if (!ctrl_a_d[ACS_EN_BIT])
    begin
      ctrl_a_d[ACS_START_BIT] = 1'b0;
      pend_d = 1'b0;
    end
  end

  // prescaler held in reset while disabled, restarted by a trigger
  always_comb
  begin
    pre_d = pre_q + 7'h01;
    if (!ctrl_a_q[ACS_EN_BIT] || adc_edge)
      pre_d = 7'h00;
    if (sync_q[2] && st_q == ACS_IDLE)
      pre_d = 7'h00;
  end

  // trigger edge detection; edges during conversion are dropped
  always_comb
  begin
    trig_d = trig_now;
    sync_d = {sync_q[1:0], 1'b0};
    if (ctrl_a_q[ACS_ATE_BIT] && !free_run && trig_now && !trig_q && st_q == ACS_IDLE && sync_q == 3'h0 && !pend_q)
      sync_d[0] = 1'b1;
  end

  // conversion sequencer counting converter half cycles
  always_comb
  begin
    st_d = st_q;
    half_d = half_q;
    len_d = len_q;
    sh_d = sh_q;
    first_d = first_q;
    if (!ctrl_a_q[ACS_EN_BIT])
      first_d = 1'b1;
    case (st_q)
      ACS_IDLE:
      begin
        if (start_req || auto_start)
        begin
          st_d = ACS_CONV;
          half_d = 6'h00;
          len_d = first_q ? ACS_FIRST_CYC : ACS_NORM_CYC;
          sh_d = first_q ? ACS_FIRST_SH_HALF : (auto_start ? ACS_AUTO_SH_HALF : ACS_NORM_SH_HALF);
          first_d = 1'b0;
        end
      end
      ACS_CONV:
      begin
        if (adc_edge || adc_fall)
          half_d = half_q + 6'h01;
        if (done)
        begin
          half_d = 6'h00;
          st_d = free_run ? ACS_CONV : ACS_IDLE;
          len_d = ACS_NORM_CYC;
          sh_d = ACS_NORM_SH_HALF;
        end
      end
      default: st_d = ACS_IDLE;
    endcase
    // follow the enable as written, so the start bit and the state drop together
    if (!ctrl_a_d[ACS_EN_BIT])
      st_d = ACS_IDLE;
  end

  // selection buffer, while enabled: copy when idle or in last cycle, frozen otherwise
  always_comb
  begin
    sel_d = sel_q;
    if (ctrl_a_q[ACS_EN_BIT] && (st_q == ACS_IDLE || half_q >= (len_q << 1) - 6'h02))
      sel_d = '{ref_sel: insel_q[7:6], chan_sel: insel_q[3:0]};
  end

  // result registers with low-then-high read lock
  always_comb
  begin
    res_d = res_q;
    lock_d = lock_q;
    if (apb_rd && PADDR_I == ACS_RES_LO_OFS)
      lock_d = 1'b1;
    if (apb_rd && PADDR_I == ACS_RES_HI_OFS)
      lock_d = 1'b0;
    if (done && !lock_q)
      res_d = CONV_CODE_I;
  end

  // register stage
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      ctrl_a_q <= 32'h0000_0000;
      tsel_q <= 3'h0;
      insel_q <= 8'h00;
      pwr_red_q <= ACS_PWR_RST[0];
      pend_q <= 1'b0;
      pre_q <= 7'h00;
      trig_q <= 1'b0;
      sync_q <= 3'h0;
      st_q <= ACS_IDLE;
      half_q <= 6'h00;
      len_q <= ACS_NORM_CYC;
      sh_q <= ACS_NORM_SH_HALF;
      first_q <= 1'b1;
      sel_q <= '0;
      res_q <= 10'h000;
      lock_q <= 1'b0;
      SAMPLE_O <= 1'b0;
      CONV_DONE_O <= 1'b0;
    end
    else
    begin
      ctrl_a_q <= ctrl_a_d;
      tsel_q <= tsel_d;
      insel_q <= insel_d;
      pwr_red_q <= pwr_red_d;
      pend_q <= pend_d;
      pre_q <= pre_d;
      trig_q <= trig_d;
      sync_q <= sync_d;
      st_q <= st_d;
      half_q <= half_d;
      len_q <= len_d;
      sh_q <= sh_d;
      first_q <= first_d;
      sel_q <= sel_d;
      res_q <= res_d;
      lock_q <= lock_d;
      SAMPLE_O <= sample;
      CONV_DONE_O <= done;
    end
  end

  assign SEL_O = sel_q;
  assign CONV_BUSY_O = (st_q == ACS_CONV);

  // assertions
  property p_start_reads_one;
    @(posedge CORE_CLK_I) disable iff (!RST_N_I) (st_q == ACS_CONV) |-> ctrl_a_q[ACS_START_BIT];
  endproperty
  a_start_reads_one: assert property (p_start_reads_one) else $error("start bit low in conversion");
  property p_done_sets_flag;
    @(posedge CORE_CLK_I) disable iff (!RST_N_I) done |=> ctrl_a_q[ACS_DONE_BIT];
  endproperty
  a_done_sets_flag: assert property (p_done_sets_flag) else $error("done flag not set");
  property p_single_clears;
    @(posedge CORE_CLK_I) disable iff (!RST_N_I) (done && !free_run && ctrl_a_q[ACS_EN_BIT])
      |=> !ctrl_a_q[ACS_START_BIT] && st_q == ACS_IDLE;
  endproperty
  a_single_clears: assert property (p_single_clears) else $error("start bit not cleared");
  property p_free_keeps;
    @(posedge CORE_CLK_I) disable iff (!RST_N_I) (done && free_run && ctrl_a_d[ACS_EN_BIT])
      |=> st_q == ACS_CONV && ctrl_a_q[ACS_START_BIT];
  endproperty
  a_free_keeps: assert property (p_free_keeps) else $error("free run stopped");
  property p_pre_reset;
    @(posedge CORE_CLK_I) disable iff (!RST_N_I) !ctrl_a_q[ACS_EN_BIT] |=> pre_q == 7'h00;
  endproperty
  a_pre_reset: assert property (p_pre_reset) else $error("prescaler runs while disabled");
  property p_sel_frozen;
    @(posedge CORE_CLK_I) disable iff (!RST_N_I) (st_q == ACS_CONV && $past(st_q) == ACS_CONV
      && half_q < (len_q << 1) - 6'h02 && half_q != 6'h00) |-> $stable(sel_q);
  endproperty
  a_sel_frozen: assert property (p_sel_frozen) else $error("selection changed in conversion");
  property p_lock;
    @(posedge CORE_CLK_I) disable iff (!RST_N_I) (done && lock_q) |=> $stable(res_q);
  endproperty
  a_lock: assert property (p_lock) else $error("result updated while locked");
  property p_sync3;
    @(posedge CORE_CLK_I) disable iff (!RST_N_I) (sync_q[0] && st_q == ACS_IDLE)
      |-> ##2 st_q == ACS_IDLE ##1 st_q == ACS_CONV;
  endproperty
  a_sync3: assert property (p_sync3) else $error("trigger sync not three cycles");
  property p_no_power;
    @(posedge CORE_CLK_I) disable iff (!RST_N_I) (pwr_red_q && !ctrl_a_q[ACS_ATE_BIT] && st_q == ACS_IDLE && !pend_q)
      |=> st_q == ACS_IDLE;
  endproperty
  a_no_power: assert property (p_no_power) else $error("started under power reduction");

  // helper for the checks: core cycles spent in the running conversion
  logic [11:0] conv_cyc_q, conv_cyc_d;
  always_comb
  begin
    conv_cyc_d = conv_cyc_q + 12'h001;
    if (st_q != ACS_CONV || done)
      conv_cyc_d = 12'h000;
  end
  // helper register, apart from the half cycle count so it can judge it
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      conv_cyc_q <= 12'h000;
    else
      conv_cyc_q <= conv_cyc_d;
  end
  property p_conv_len;
    @(posedge CORE_CLK_I) disable iff (!RST_N_I) done |-> conv_cyc_q == ({6'h00, len_q} * {4'h0, pre_div}) - 12'h001;
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");
  property p_start_edge;
    @(posedge CORE_CLK_I) disable iff (!RST_N_I) (start_req && ctrl_a_d[ACS_EN_BIT]) |=> st_q == ACS_CONV;
  endproperty
  a_start_edge: assert property (p_start_edge) else $error("software start not taken at edge");
  property p_auto_pre;
    @(posedge CORE_CLK_I) disable iff (!RST_N_I) auto_start |=> pre_q == 7'h00;
  endproperty
  a_auto_pre: assert property (p_auto_pre) else $error("prescaler not reset by trigger");
  property p_edge_ignored;
    @(posedge CORE_CLK_I) disable iff (!RST_N_I) (st_q == ACS_CONV && ctrl_a_q[ACS_ATE_BIT] && trig_now && !trig_q)
      |=> !sync_q[0];
  endproperty
  a_edge_ignored: assert property (p_edge_ignored) else $error("trigger edge taken in conversion");
  property p_sel_en;
    @(posedge CORE_CLK_I) disable iff (!RST_N_I) !ctrl_a_q[ACS_EN_BIT] |=> $stable(sel_q);
  endproperty
  a_sel_en: assert property (p_sel_en) else $error("selection applied while disabled");
  c_single: cover property (@(posedge CORE_CLK_I) disable iff (!RST_N_I) done && !free_run);
  c_free: cover property (@(posedge CORE_CLK_I) disable iff (!RST_N_I) done && free_run);
  c_auto: cover property (@(posedge CORE_CLK_I) disable iff (!RST_N_I) auto_start);
  c_lost: cover property (@(posedge CORE_CLK_I) disable iff (!RST_N_I) done && lock_q);
  c_first: cover property (@(posedge CORE_CLK_I) disable iff (!RST_N_I) done && len_q == ACS_FIRST_CYC);
endmodule // acs_adc_conversion_sequencer
`default_nettype wire

// [bench/acs_afe_model.sv]
`timescale 1ns/1ps
`default_nettype none
module acs_afe_model
(
  input wire logic clk_i, // core clock
  input wire logic rst_n_i, // async reset, active low
  input wire logic sample_i, // sample and hold instant
  input wire logic [5:0] sel_i, // frozen reference and channel
  input wire logic done_i, // end of conversion pulse
  output logic [9:0] code_o // code of the approximation array
);
  logic [9:0] code_q;
  logic [9:0] code_d;

  assign code_o = code_q;

  // code tells which channel was held; after done it is inverted so stale data never passes as good
  always_comb
  begin
    code_d = code_q;
    if (done_i)
      code_d = ~code_q;
    if (sample_i)
      code_d = {sel_i[3:0], 6'h2A};
  end

  // code register
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      code_q <= 10'h3FF;
    else
      code_q <= code_d;
  end
endmodule // acs_afe_model
`default_nettype wire

// [bench/acs_adc_conversion_sequencer_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_mismatch++; \
  $display("mismatch t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module acs_adc_conversion_sequencer_tb_top;
  import acs_pkg::*;
  localparam logic [31:0] EN = 32'h1 << ACS_EN_BIT;
  localparam logic [31:0] ST = 32'h1 << ACS_START_BIT;
  localparam logic [31:0] ATE = 32'h1 << ACS_ATE_BIT;
  localparam logic [31:0] DN = 32'h1 << ACS_DONE_BIT;
  localparam int DIV = 2; // prescaler select 0 divides by two
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, sample, done, busy, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:1] trig;
  logic [9:0] code;
  logic [5:0] sel;
  logic [3:0] sel_log [0:63];
  int n_mismatch, n_tests, n_done, n_smp, cyc_cnt, ts1, td1, ts2, td2, k;

  acs_adc_conversion_sequencer #(.TRIG_W(8)) dut (.CORE_CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel),
    .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .TRIG_I(trig), .CONV_CODE_I(code), .SAMPLE_O(sample),
    .SEL_O(sel), .CONV_DONE_O(done), .CONV_BUSY_O(busy));
  acs_afe_model afe (.clk_i(clk), .rst_n_i(rst_n), .sample_i(sample), .sel_i(sel), .done_i(done),
    .code_o(code));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // event log; the timeout cuts a hang short
  always @(posedge clk)
  begin
    if (done === 1'b1) n_done++;
    if (sample === 1'b1)
    begin
      sel_log[n_smp[5:0]] = sel[3:0];
      n_smp++;
    end
    cyc_cnt++;
    if (cyc_cnt == 60000)
    begin
      n_mismatch++;
      wrap_up();
    end
  end

  task automatic wrap_up;
    $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // one apb transfer; request held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask
  task automatic bus_rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0, rd);
  endtask
  task automatic tick;
    @(posedge clk); #1;
  endtask
  task automatic wait_busy(input logic v);
    for (int i = 0; i < 3000 && busy !== v; i++) tick();
    `CHK(busy, v)
  endtask
  task automatic wait_n(input int n);
    int tgt;
    tgt = n_done + n;
    for (int i = 0; i < 3000 && n_done < tgt; i++) tick();
    `CHK(n_done, tgt)
  endtask
  // cycles from conversion start to sample pulse and to done pulse
  task automatic measure(output int ts, output int td);
    ts = -1; td = -1;
    for (int i = 1; i < 3000 && td < 0; i++)
    begin
      tick();
      if (sample === 1'b1) ts = i;
      if (done === 1'b1) td = i;
    end
  endtask

  task automatic t_power;
    bus_rd(ACS_PWR_OFS);
    `CHK(rd, ACS_PWR_RST)
    bus_wr(ACS_CTRL_A_OFS, EN | ST);
    repeat (60) tick();
    `CHK(busy, 1'b0)
    `CHK(n_done, 0)
    bus_wr(ACS_CTRL_A_OFS, 32'h0);
    bus_wr(ACS_PWR_OFS, 32'h0);
  endtask

  task automatic t_first;
    bus_wr(ACS_INSEL_OFS, 32'h03);
    tick();
    `CHK(sel[3:0], 4'h0)
    bus_wr(ACS_CTRL_A_OFS, EN | ST);
    wait_busy(1'b1);
    measure(ts1, td1);
    bus_rd(ACS_CTRL_A_OFS);
    `CHK(rd[ACS_START_BIT], 1'b0)
    `CHK(rd[ACS_DONE_BIT], 1'b1)
    bus_rd(ACS_RES_LO_OFS);
    `CHK(rd[7:0], 8'hEA)
    bus_rd(ACS_RES_HI_OFS);
    `CHK(rd[7:0], 8'h00)
    bus_wr(ACS_CTRL_A_OFS, EN | ST | DN);
    wait_busy(1'b1);
    measure(ts2, td2);
    `CHK(td1 - td2, 12 * DIV)
    `CHK(ts1 - ts2, 12 * DIV)
  endtask

  task automatic t_chan;
    bus_wr(ACS_CTRL_A_OFS, EN | ST | DN);
    wait_busy(1'b1);
    repeat (DIV) tick();
    bus_rd(ACS_CTRL_A_OFS);
    `CHK(rd[ACS_START_BIT], 1'b1)
    bus_wr(ACS_INSEL_OFS, 32'h05);
    tick();
    `CHK(sel[3:0], 4'h3)
    wait_busy(1'b0);
    repeat (2) tick();
    `CHK(sel[3:0], 4'h5)
  endtask

  task automatic t_lock;
    bus_rd(ACS_RES_LO_OFS);
    bus_wr(ACS_CTRL_A_OFS, EN | ST | DN);
    wait_busy(1'b1);
    wait_busy(1'b0);
    bus_rd(ACS_CTRL_A_OFS);
    `CHK(rd[ACS_DONE_BIT], 1'b1)
    bus_rd(ACS_RES_HI_OFS);
    `CHK(rd[7:0], 8'h00)
    bus_wr(ACS_INSEL_OFS, 32'hE5);
    bus_wr(ACS_CTRL_A_OFS, EN | ST | DN);
    wait_n(1);
    `CHK(sel[5:4], 2'h3)
    bus_wr(ACS_CTRL_A_OFS, EN | ST | DN);
    wait_busy(1'b1);
    wait_busy(1'b0);
    bus_rd(ACS_RES_LO_OFS);
    `CHK(rd[7:0], 8'h80)
    bus_rd(ACS_RES_HI_OFS);
    `CHK(rd[7:0], 8'h5A)
  endtask

  task automatic t_auto;
    bus_wr(ACS_CTRL_B_OFS, 32'h1);
    bus_wr(ACS_CTRL_A_OFS, EN | ATE | DN);
    k = n_done;
    @(posedge clk) trig[1] <= 1'b1;
    wait_busy(1'b1);
    bus_rd(ACS_CTRL_A_OFS);
    `CHK(rd[ACS_START_BIT], 1'b1)
    @(posedge clk) trig[1] <= 1'b0;
    @(posedge clk) trig[1] <= 1'b1;
    wait_busy(1'b0);
    repeat (80) tick();
    `CHK(n_done - k, 1)
    @(posedge clk) trig[1] <= 1'b0;
    bus_wr(ACS_CTRL_A_OFS, EN | ATE | ST | DN);
    wait_n(1);
  endtask

  task automatic t_free;
    bus_wr(ACS_CTRL_B_OFS, {29'h0, ACS_TS_FREE});
    k = n_smp;
    bus_wr(ACS_CTRL_A_OFS, EN | ATE | ST | DN);
    wait_n(1);
    bus_wr(ACS_INSEL_OFS, 32'h07);
    wait_n(2);
    bus_rd(ACS_CTRL_A_OFS);
    `CHK(rd[ACS_START_BIT], 1'b1)
    `CHK(sel_log[k + 1], 4'h5)
    `CHK(sel_log[k + 2], 4'h7)
    bus_wr(ACS_CTRL_A_OFS, EN);
    wait_busy(1'b0);
  endtask

  task automatic t_unmapped;
    bus_rd(8'h18);
    `CHK(err, 1'b1)
    `CHK(rd, 32'h0)
  endtask

  initial
  begin
    rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h0; pwdata = 32'h0;
    trig = 7'h0; n_mismatch = 0; n_tests = 0; n_done = 0; n_smp = 0; cyc_cnt = 0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_power();
    t_first();
    t_chan();
    t_lock();
    t_auto();
    t_free();
    t_unmapped();
    wrap_up();
  end
endmodule // acs_adc_conversion_sequencer_tb_top
`default_nettype wire
